// ---- fpec_regs.svh ----
// Notes on behaviour
// - one 24-bit word programmed; erase page first
// - key 0x55 then 0xAA right before start
// - software puts two idle slots after start
// - software waits whole cycle time before done
// - last page erase also clears configuration words
// - start bit 15 set-only, hardware clears
// - permit bit 14 gates program and erase
// - fault flag bit 13 on improper sequence
// - selector bit 6: erase one, program zero
// - erase codes: 0010 page, 1101 segment
// - program code 0011 word, listed codes nop
// - control bits cleared only by power-on reset
// - control bits 12-7, 5-4 read zero
// - key register write-only, low byte only
// - core stalled while cycle runs; the code stalls only control and key register accesses
// - pages of eight 64-word rows, 1536 bytes
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH

// ****************************************
// host register offsets (AHB byte address)
// ****************************************
`define FPEC_OFF_CTRL     32'h0000_0000
`define FPEC_OFF_KEY      32'h0000_0004
`define FPEC_OFF_STATUS   32'h0000_0008
`define FPEC_OFF_IRQ_STAT 32'h0000_000c
`define FPEC_OFF_IRQ_MASK 32'h0000_0010

// ****************************************
// control register fields
// ****************************************
`define FPEC_BIT_START    15
`define FPEC_BIT_PERMIT   14
`define FPEC_BIT_FAULT    13
`define FPEC_BIT_ERASE    6
`define FPEC_CTRL_RESET   16'h0000
`define FPEC_OP_NONE0     4'h0
`define FPEC_OP_NONE1     4'h1
`define FPEC_OP_PAGE      4'h2
`define FPEC_OP_WORD      4'h3
`define FPEC_OP_NONEC     4'hc
`define FPEC_OP_SEG       4'hd
`define FPEC_OP_NONEF     4'hf
`define FPEC_KEY_FIRST    8'h55
`define FPEC_KEY_SECOND   8'haa

// ****************************************
// memory geometry and timing
// ****************************************
`define FPEC_ROW_WORDS    64
`define FPEC_PAGE_ROWS    8
`define FPEC_PAGE_MASK    24'hfffc00
`define FPEC_IRQ_DONE     0
`define FPEC_IRQ_FAULT    1
`define FPEC_HOLDOFF      2'h2
`define FPEC_CLK_MHZ      64'd250
`define FPEC_T_WORD_NS    64'd47400
`define FPEC_T_ERASE_NS   64'd20000000
`define FPEC_T_SEG_NS     64'd40000000
`define FPEC_CYC(ns)      ((((ns) * `FPEC_CLK_MHZ) + 64'd999) / 64'd1000)

`endif

// ---- fpec_pkg.sv ----
package fpec_pkg;
  typedef enum logic [1:0] {
    FPEC_IDLE = 2'b00,
    FPEC_RUN  = 2'b01,
    FPEC_FIN  = 2'b10
  } fpec_state_t;

  typedef enum logic [2:0] {
    FPEC_K_NOP  = 3'b000,
    FPEC_K_WORD = 3'b001,
    FPEC_K_PAGE = 3'b010,
    FPEC_K_SEG  = 3'b011,
    FPEC_K_BAD  = 3'b100
  } fpec_kind_t;

  typedef enum logic [1:0] {
    FPEC_KEY_NONE  = 2'b00,
    FPEC_KEY_HALF  = 2'b01,
    FPEC_KEY_ARMED = 2'b10
  } fpec_key_t;
endpackage

// ---- fpec_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fpec_if;
  logic        wr;
  logic        sel;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        stall;
  logic        done;
  logic        fault;

  modport dev (
    input  wr,
    input  sel,
    input  wdata,
    output rdata,
    output stall,
    output done,
    output fault
  );

  modport host (
    output wr,
    output sel,
    output wdata,
    input  rdata,
    input  stall,
    input  done,
    input  fault
  );
endinterface
`default_nettype wire

// ---- fpec_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpec_timer #(
  parameter int W = 28
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         load,
  input  wire logic         abort,
  input  wire logic [W-1:0] count,
  output logic              expired
);
  logic [W-1:0] remain;
  logic         running;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remain  <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (abort) begin
        running <= 1'b0;
      end else if (load) begin
        remain  <= count - W'(1);
        running <= 1'b1;
      end else if (running) begin
        if (remain == '0) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          remain <= remain - W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- fpec_device.sv ----
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_regs.svh"
module fpec_device #(
  parameter int          WORD_CYCLES  = int'(`FPEC_CYC(`FPEC_T_WORD_NS)),
  parameter int          ERASE_CYCLES = int'(`FPEC_CYC(`FPEC_T_ERASE_NS)),
  parameter int          SEG_CYCLES   = int'(`FPEC_CYC(`FPEC_T_SEG_NS)),
  parameter logic [23:0] LAST_PAGE    = 24'h005800
) (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  warm_rstn,
  fpec_if.dev        bus,
  input  wire logic [23:0] tgt_addr,
  input  wire logic [23:0] tgt_data,
  output logic       flash_word_pgm,
  output logic       flash_page_erase,
  output logic       flash_seg_erase,
  output logic [23:0] flash_addr,
  output logic [23:0] flash_data,
  output logic       cfg_clear
);
  import fpec_pkg::*;

  localparam int TW = 28;

  // ****************************************
  // register state
  // ****************************************
  logic        start;
  logic        permit;
  logic        fault;
  logic        erase_sel;
  logic [3:0]  op_field;
  fpec_key_t   key_st;
  fpec_state_t state;
  fpec_kind_t  kind;
  logic        done_p;
  logic        fault_p;

  logic        ctrl_wr;
  logic        key_wr;
  logic        start_req;
  logic        new_permit;
  fpec_kind_t  new_kind;
  logic        launch;
  logic        bad_try;
  logic        abort;
  logic        timer_load;
  logic [TW-1:0] timer_count;
  logic        expired;

  function automatic fpec_kind_t classify(input logic ers,
                                          input logic [3:0] op);
    fpec_kind_t k;
    k = FPEC_K_BAD;
    case (op)
      `FPEC_OP_PAGE: k = ers ? FPEC_K_PAGE : FPEC_K_NOP;
      `FPEC_OP_SEG:  k = ers ? FPEC_K_SEG : FPEC_K_NOP;
      `FPEC_OP_WORD: k = ers ? FPEC_K_NOP : FPEC_K_WORD;
      `FPEC_OP_NONE0, `FPEC_OP_NONE1,
      `FPEC_OP_NONEC, `FPEC_OP_NONEF: k = FPEC_K_NOP;
      default:       k = FPEC_K_BAD;
    endcase
    return k;
  endfunction

  // ****************************************
  // request decode
  // ****************************************
  assign ctrl_wr    = bus.wr & ~bus.sel;
  assign key_wr     = bus.wr & bus.sel;
  // start can only be set by software, never cleared by it
  assign start_req  = ctrl_wr & bus.wdata[`FPEC_BIT_START] & ~start;
  assign new_permit = bus.wdata[`FPEC_BIT_PERMIT];
  assign new_kind   = classify(bus.wdata[`FPEC_BIT_ERASE],
                               bus.wdata[3:0]);
  assign launch     = start_req & (key_st == FPEC_KEY_ARMED)
                    & new_permit & (new_kind != FPEC_K_BAD)
                    & warm_rstn;
  assign bad_try    = start_req & ~launch;
  // a warm reset in mid cycle cuts the array operation short
  assign abort      = ~warm_rstn & (state == FPEC_RUN);

  always_comb begin
    timer_load  = launch & (new_kind != FPEC_K_NOP);
    timer_count = TW'(WORD_CYCLES);
    case (new_kind)
      FPEC_K_PAGE: timer_count = TW'(ERASE_CYCLES);
      FPEC_K_SEG:  timer_count = TW'(SEG_CYCLES);
      default:     timer_count = TW'(WORD_CYCLES);
    endcase
  end

  fpec_timer #(
    .W       (TW)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (timer_load),
    .abort   (abort),
    .count   (timer_count),
    .expired (expired)
  );

  // ****************************************
  // control fields, power-on reset only
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      permit    <= 1'b0;
      erase_sel <= 1'b0;
      op_field  <= 4'h0;
    end else if (ctrl_wr && state == FPEC_IDLE) begin
      permit    <= bus.wdata[`FPEC_BIT_PERMIT];
      erase_sel <= bus.wdata[`FPEC_BIT_ERASE];
      op_field  <= bus.wdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start <= 1'b0;
    end else if (launch) begin
      start <= 1'b1;
    end else if (state == FPEC_FIN || abort) begin
      start <= 1'b0;
    end
  end

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault <= 1'b0;
    end else if (bad_try || abort) begin
      fault <= 1'b1;
    end else if (ctrl_wr) begin
      fault <= bus.wdata[`FPEC_BIT_FAULT];
    end
  end

  // ****************************************
  // unlock key sequence
  // ****************************************
  // a control register write between the two keys breaks the sequence; status and interrupt register writes do not
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_st <= FPEC_KEY_NONE;
    end else if (!warm_rstn || ctrl_wr) begin
      key_st <= FPEC_KEY_NONE;
    end else if (key_wr) begin
      if (bus.wdata[7:0] == `FPEC_KEY_FIRST) begin
        key_st <= FPEC_KEY_HALF;
      end else if (key_st == FPEC_KEY_HALF &&
                   bus.wdata[7:0] == `FPEC_KEY_SECOND) begin
        key_st <= FPEC_KEY_ARMED;
      end else begin
        key_st <= FPEC_KEY_NONE;
      end
    end
  end

  // ****************************************
  // cycle sequencer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= FPEC_IDLE;
      kind  <= FPEC_K_NOP;
    end else begin
      case (state)
        FPEC_IDLE: begin
          if (launch) begin
            kind  <= new_kind;
            state <= (new_kind == FPEC_K_NOP) ? FPEC_FIN : FPEC_RUN;
          end
        end
        FPEC_RUN: begin
          if (abort) begin
            state <= FPEC_IDLE;
          end else if (expired) begin
            state <= FPEC_FIN;
          end
        end
        FPEC_FIN: state <= FPEC_IDLE;
        default:  state <= FPEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_p  <= 1'b0;
      fault_p <= 1'b0;
    end else begin
      done_p  <= (state == FPEC_FIN);
      fault_p <= bad_try | abort;
    end
  end

  // ****************************************
  // flash array strobes
  // ****************************************
  // erase base snaps to a 1536-byte page, word program keeps full address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_word_pgm   <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_seg_erase  <= 1'b0;
      flash_addr       <= 24'h000000;
      flash_data       <= 24'h000000;
      cfg_clear        <= 1'b0;
    end else begin
      cfg_clear <= 1'b0;
      if (timer_load) begin
        flash_word_pgm   <= (new_kind == FPEC_K_WORD);
        flash_page_erase <= (new_kind == FPEC_K_PAGE);
        flash_seg_erase  <= (new_kind == FPEC_K_SEG);
        flash_data       <= tgt_data;
        if (new_kind == FPEC_K_WORD) begin
          flash_addr <= tgt_addr;
        end else begin
          flash_addr <= tgt_addr & `FPEC_PAGE_MASK;
        end
        // last page holds the configuration words
        cfg_clear <= (new_kind == FPEC_K_PAGE) &&
                     ((tgt_addr & `FPEC_PAGE_MASK) == LAST_PAGE);
      end else if (expired || abort) begin
        flash_word_pgm   <= 1'b0;
        flash_page_erase <= 1'b0;
        flash_seg_erase  <= 1'b0;
      end
    end
  end

  // ****************************************
  // core-facing outputs
  // ****************************************
  assign bus.stall = (state != FPEC_IDLE);
  assign bus.done  = done_p;
  assign bus.fault = fault_p;
  assign bus.rdata = {start, permit, fault, 6'h00,
                      erase_sel, 2'b00, op_field};
endmodule
`default_nettype wire

// ---- fpec_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpec_regs.svh"
module fpec_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  fpec_if.host             bus
);
  import fpec_pkg::*;

  logic [31:0] dp_addr;
  logic        dp_valid;
  logic        dp_write;
  logic        dp_dev;
  logic        accept;
  logic [1:0]  holdoff;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic        dp_done;
  logic [31:0] next_rd_addr;
  logic [31:0] next_hrdata;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign accept = hsel & htrans[1] & hready;
  assign dp_dev = (dp_addr == `FPEC_OFF_CTRL) | (dp_addr == `FPEC_OFF_KEY);
  // the core stalls on flash registers while a cycle runs
  assign hreadyout = ~(dp_valid & dp_dev &
                       (bus.stall | (holdoff != 2'h0)));
  assign hresp   = 1'b0;
  assign dp_done = dp_valid & hreadyout;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 32'h0000_0000;
    end else if (hready) begin
      dp_valid <= accept;
      dp_write <= hwrite;
      dp_addr  <= haddr;
    end
  end

  assign bus.wr    = dp_done & dp_write & dp_dev;
  assign bus.sel   = (dp_addr == `FPEC_OFF_KEY);
  assign bus.wdata = hwdata[15:0];

  // two idle slots after a start write, plus one after the stall ends:
  // hrdata is registered, so a waited read needs the cleared start bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      holdoff <= 2'h0;
    end else if (bus.wr && !bus.sel && hwdata[`FPEC_BIT_START]) begin
      holdoff <= `FPEC_HOLDOFF;
    end else if (bus.stall) begin
      holdoff <= 2'h1;
    end else if (holdoff != 2'h0) begin
      holdoff <= holdoff - 2'h1;
    end
  end

  // ****************************************
  // read data, registered
  // ****************************************
  always_comb begin
    next_rd_addr = accept ? haddr : dp_addr;
    next_hrdata  = 32'h0000_0000;
    case (next_rd_addr)
      `FPEC_OFF_CTRL:     next_hrdata = {16'h0000, bus.rdata};
      `FPEC_OFF_STATUS:   next_hrdata = {31'h0000_0000, bus.stall};
      `FPEC_OFF_IRQ_STAT: next_hrdata = {30'h0000_0000, irq_stat};
      `FPEC_OFF_IRQ_MASK: next_hrdata = {30'h0000_0000, irq_mask};
      default:            next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // completion reported when a cycle reaches FPEC_FIN, no-op commands included; an aborted cycle reports none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= 2'b00;
    end else begin
      if (dp_done && dp_write && dp_addr == `FPEC_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~hwdata[1:0]) |
                    {bus.fault, bus.done};
      end else begin
        irq_stat <= irq_stat | {bus.fault, bus.done};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= 2'b00;
    end else if (dp_done && dp_write &&
                 dp_addr == `FPEC_OFF_IRQ_MASK) begin
      irq_mask <= hwdata[1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

// ---- fpec_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpec_chk #(
  parameter int WORD_CYCLES  = 20,
  parameter int ERASE_CYCLES = 30,
  parameter int SEG_CYCLES   = 40
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        wr,
  input wire logic        sel,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        stall,
  input wire logic        done,
  input wire logic        fault
);
  // ****************************************
  // key tracking and cycle timing
  // ****************************************
  logic [1:0]  key_st;
  logic [15:0] run_cnt;
  logic [4:0]  op_cap;
  logic        stall_q;
  logic        flt_seen;
  logic        flt_rise;
  int          lo;
  wire         impl = wdata[3:0] inside {4'hf, 4'hd, 4'hc, [4'h0:4'h3]};
  wire         go   = wr && !sel && wdata[15];
  wire         ok   = go && wdata[14] && key_st == 2'h2 && impl;
  wire         bad  = go && !ok;
  wire         rise = stall && !stall_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_st <= 2'h0;
    end else if (wr) begin
      key_st <= !sel ? 2'h0 : wdata[7:0] == 8'h55 ? 2'h1 :
                (wdata[7:0] == 8'haa && key_st == 2'h1) ? 2'h2 : 2'h0;
    end
  end

  // a fault inside a run marks it aborted, so its length is not judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_q  <= 1'b0;
      run_cnt  <= 16'h0;
      op_cap   <= 5'h0;
      flt_seen <= 1'b0;
      flt_rise <= 1'b0;
    end else begin
      stall_q  <= stall;
      run_cnt  <= rise ? 16'h1 : run_cnt + 16'h1;
      flt_seen <= rise ? 1'b0 : (flt_seen || fault);
      if (rise) begin
        op_cap   <= {rdata[6], rdata[3:0]};
        flt_rise <= rdata[13];
      end
    end
  end

  assign lo = op_cap == 5'h03 ? WORD_CYCLES : op_cap == 5'h12 ?
              ERASE_CYCLES : op_cap == 5'h1d ? SEG_CYCLES : 1;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  refuse_fault_a: assert property (bad |-> ##[1:2] fault)
    else $error("refused start without fault pulse");
  launch_run_a: assert property (ok |=> stall && rdata[15])
    else $error("keyed start did not launch");
  done_clear_a: assert property (done && !wr |=> !stall && !rdata[15])
    else $error("start or stall left after done");
  cycle_time_a: assert property (
    done && !fault && !flt_seen |-> run_cnt >= lo && run_cnt <= lo + 4)
    else $error("cycle length off");
  clean_done_a: assert property (
    done && !fault && !flt_seen && !flt_rise |-> !rdata[13])
    else $error("fault flag after clean cycle");
  stall_nowr_a: assert property (stall |-> !wr)
    else $error("write reached device while stalled");
  unimpl_zero_a: assert property (
    rdata[12:7] == 6'h0 && rdata[5:4] == 2'h0)
    else $error("unimplemented control bits set");
  fault_flag_a: assert property (fault |-> ##[0:1] rdata[13])
    else $error("fault pulse without flag");

  cover property (ok ##1 stall);
  cover property (bad ##[1:2] fault);
  cover property (done && op_cap == 5'h1d);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpec_regs.svh"
module tb_top;
  localparam int          LIM = 400;
  localparam int          WCY = 20;
  localparam int          ECY = 30;
  localparam int          SCY = 40;
  localparam logic [31:0] CTL = `FPEC_OFF_CTRL;
  localparam logic [31:0] KEY = `FPEC_OFF_KEY;
  localparam logic [31:0] STA = `FPEC_OFF_STATUS;
  localparam logic [31:0] IST = `FPEC_OFF_IRQ_STAT;
  localparam logic [31:0] IMS = `FPEC_OFF_IRQ_MASK;
  logic        hclk, hresetn, warm_rstn, hsel, hwrite, hresp, irq;
  logic        hreadyout, cfg_clear, f_word, f_page, f_seg, dp_rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, op_now, op_prev;
  logic [23:0] tgt_addr, tgt_data, flash_addr, flash_data, ta, td;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] rd_q[$];
  logic [50:0] op_q[$];
  logic [31:0] bad[4] = '{32'h5555c003, 32'h55aa8003, 32'haaaac003,
                          32'h55aac00a};
  logic [18:0] ops[4] = '{19'h1c003, 19'h2c042, 19'h2c042, 19'h4c04d};
  logic [15:0] nops[11] = '{16'hc04f, 16'hc04c, 16'hc043, 16'hc041,
    16'hc040, 16'hc00f, 16'hc00d, 16'hc00c, 16'hc002, 16'hc001, 16'hc000};
  int          err_count, check_count, cfg_n;

  fpec_if fpec_if_i ();
  fpec_host fpec_host_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .bus(fpec_if_i));
  fpec_device #(.WORD_CYCLES(WCY), .ERASE_CYCLES(ECY), .SEG_CYCLES(SCY))
  fpec_device_i (
    .hclk, .hresetn, .warm_rstn, .bus(fpec_if_i), .tgt_addr, .tgt_data,
    .flash_word_pgm(f_word), .flash_page_erase(f_page),
    .flash_seg_erase(f_seg), .flash_addr, .flash_data, .cfg_clear);
  // checker defaults equal the bench cycle counts above
  fpec_chk fpec_chk_i (
    .hclk, .hresetn, .wr(fpec_if_i.wr), .sel(fpec_if_i.sel),
    .wdata(fpec_if_i.wdata), .rdata(fpec_if_i.rdata),
    .stall(fpec_if_i.stall), .done(fpec_if_i.done), .fault(fpec_if_i.fault));

  // ****************************************
  // bus tasks and result monitor
  // ****************************************
  task automatic fail(input string m);
    $display("MISMATCH %0t %s", $time, m);
    err_count++;
  endtask

  task automatic results();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin
      fail(m);
    end
  endtask

  // control and key accesses wait out a running cycle, so no fixed delay
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      fail("bus timeout");
      results();
    end
  endtask

  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hwait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic go(input logic [15:0] c);
    xfer(KEY, 1'b1, 32'h55);
    xfer(KEY, 1'b1, 32'haa);
    xfer(CTL, 1'b1, {16'h0, c});
  endtask

  always @(posedge hclk) begin
    if (dp_rd && hreadyout === 1'b1) begin
      check_count++;
      if (hrdata !== rd_q.pop_front()) begin
        fail("register read");
      end
      if (hresp !== 1'b0) begin
        fail("error response");
      end
    end
    if (hreadyout === 1'b1) begin
      dp_rd = hsel && htrans[1] && !hwrite;
    end
    op_now = {f_seg, f_page, f_word};
    if (op_now != 3'h0 && op_prev == 3'h0) begin
      check_count++;
      if ({op_now, flash_addr, f_word ? flash_data : 24'h0}
          !== op_q.pop_front()) begin
        fail("flash operation");
      end
    end
    op_prev = op_now;
    cfg_n += int'(cfg_clear === 1'b1);
  end

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {tgt_addr, tgt_data, dp_rd, op_prev} = '0;
    warm_rstn = 1'b1;
    hsize = 3'b010;
    void'($urandom(40));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CTL, 32'h0);
    xfer(KEY, 1'b1, 32'h55);
    rd(KEY, 32'h0);
    rd(32'h40, 32'h0);
    foreach (bad[i]) begin
      xfer(KEY, 1'b1, {24'h0, bad[i][31:24]});
      xfer(KEY, 1'b1, {24'h0, bad[i][23:16]});
      xfer(CTL, 1'b1, {16'h0, bad[i][15:0]});
      rd(CTL, {16'h0, bad[i][15:0] & 16'h7fff | 16'h2000});
      xfer(CTL, 1'b1, 32'h0);
    end
    rd(IST, 32'h2);
    chk(irq === 1'b0, "irq while masked");
    xfer(IMS, 1'b1, 32'h3);
    @(posedge hclk);
    chk(irq === 1'b1, "irq not raised");
    xfer(IST, 1'b1, 32'h2);
    @(posedge hclk);
    chk(irq === 1'b0, "irq not cleared");
    foreach (ops[i]) begin
      ta = (i == 2) ? 24'h005800 | 24'($urandom() & 32'h3ff)
                    : 24'($urandom() & 32'h3fff);
      td = 24'($urandom());
      tgt_addr <= ta;
      tgt_data <= td;
      op_q.push_back({ops[i][18:16], i == 0 ? ta : ta & 24'hfffc00,
                      i == 0 ? td : 24'h0});
      go(ops[i][15:0]);
      rd(STA, 32'h1);
      rd(CTL, {16'h0, ops[i][15:0] & 16'h7fff});
      @(posedge hclk);
      chk(irq === 1'b1, "done irq");
      xfer(IST, 1'b1, 32'h1);
    end
    foreach (nops[i]) begin
      go(nops[i]);
      rd(CTL, {16'h0, nops[i] & 16'h7fff});
    end
    op_q.push_back({3'b001, ta, td});
    go(16'hc003);
    repeat (5) @(posedge hclk);
    warm_rstn <= 1'b0;
    @(posedge hclk);
    warm_rstn <= 1'b1;
    rd(CTL, 32'h6003);
    rd(IST, 32'h3);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CTL, 32'h0);
    chk(cfg_n == 1, "config clear count");
    results();
  end
endmodule
`default_nettype wire
